// ---- rtl/drt_pkg.sv ----
// Constants and types shared by the DDR3 timing sequencer files
package drt_pkg;
	// System clock and generated CK
	localparam int CLK_SYS_PS = 4000;
	localparam int CK_DIV     = 4;     // System cycles per CK period
	localparam int CK_HALF    = 2;     // System cycles of CK high
	localparam int TCK_PS     = CLK_SYS_PS * CK_DIV;
	localparam logic [1:0] CK_LAST   = 2'h3;   // Phase before CK rises
	localparam logic [1:0] CK_LAUNCH = 2'h2;   // Phase where pins update (CK low)
	localparam logic [1:0] CK_FALL   = 2'h1;   // Phase before CK falls

	// Times in their own units
	localparam int T_RFC_NS       = 110;
	localparam int T_REFI_NORM_NS = 7800;   // 7.8 us
	localparam int T_REFI_HOT_NS  = 3900;   // 3.9 us
	localparam int T_WR_NS        = 15;     // Write recovery, plain default

	// Timer width and counts in CK periods
	localparam int TW = 10;
	localparam logic [TW-1:0] RFC_NCK       = TW'((T_RFC_NS * 1000 + TCK_PS - 1) / TCK_PS);
	localparam logic [TW-1:0] REFI_NORM_NCK = TW'((T_REFI_NORM_NS * 1000) / TCK_PS);
	localparam logic [TW-1:0] REFI_HOT_NCK  = TW'((T_REFI_HOT_NS * 1000) / TCK_PS);
	localparam logic [TW-1:0] WR_CEIL_NCK   = TW'((T_WR_NS * 1000 + TCK_PS - 1) / TCK_PS);
	localparam logic [TW-1:0] WLMRD_NCK     = 10'h028;   // 40
	localparam logic [TW-1:0] WLDQSEN_NCK   = 10'h019;   // 25
	localparam logic [TW-1:0] REFPDEN_NCK   = 10'h001;
	localparam logic [TW-1:0] ZQCS_NCK      = 10'h040;   // 64
	localparam logic [TW-1:0] XP_NCK        = 10'h003;
	localparam logic [TW-1:0] XPDLL_NCK     = 10'h00A;
	localparam logic [TW-1:0] CKE_NCK       = 10'h003;
	localparam logic [TW-1:0] MPRR_NCK      = 10'h001;
	localparam logic [TW-1:0] BURST_NCK     = 10'h004;
	localparam logic [TW-1:0] WR_START_BL8  = 10'h004;
	localparam logic [TW-1:0] WR_START_BC4  = 10'h002;
	localparam logic [TW-1:0] ONE_NCK       = 10'h001;
	localparam logic [TW-1:0] SAT_NCK       = 10'h3FF;

	// Timer slots
	localparam int T_RFC     = 0;
	localparam int T_REFPD   = 1;
	localparam int T_WLMRD   = 2;
	localparam int T_WLDQSEN = 3;
	localparam int T_WRPD    = 4;
	localparam int T_MPR     = 5;
	localparam int T_ZQ      = 6;
	localparam int T_XP      = 7;
	localparam int T_XPDLL   = 8;
	localparam int T_CKE     = 9;
	localparam int NT        = 10;

	// Event slots of the elapsed-time counters
	localparam int E_REF = 0;
	localparam int E_WL  = 1;
	localparam int E_ZQ  = 2;
	localparam int E_WR  = 3;
	localparam int E_PDX = 4;
	localparam int E_MPR = 5;
	localparam int NE    = 6;

	// RAS#, CAS#, WE# encodings
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_WR  = 3'h4;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_ZQ  = 3'h6;

	localparam int AW = 14;
	localparam int BW = 3;
	localparam int CW = 5;

	typedef enum logic [3:0] {
		OP_NOP, OP_ACT, OP_PRE, OP_RD, OP_RDA, OP_WR, OP_WRA, OP_REF,
		OP_MRS, OP_ZQCS, OP_PDE, OP_PDX, OP_WL_ON, OP_WL_PULSE, OP_WL_OFF, OP_MPR_RD
	} drt_op_t;

	typedef enum logic [1:0] {ST_RUN, ST_WLVL, ST_PDOWN} drt_st_t;
endpackage

// ---- rtl/drt_seq.sv ----
// DDR3 command sequencer that enforces refresh, leveling and power-down spacing
//
// Functional notes
// R01: After write-leveling MRS, first DQS rising edge waits at least 40 CK.
// R02: After write-leveling MRS, DQS stays undriven at least 25 CK.
// R03: After REF, no ACT or REF until 110 ns have passed.
// R04: Refresh every 7.8 us on average, 3.9 us when hot.
// R05: READ, read with auto precharge and ODT need DLL-locked exit timing; there is no ODT output here, and MPR reads wait too.
// R06: Write recovery nanoseconds convert to cycles rounding up for power-down spacing.
// R07: With auto precharge, power-down spacing uses the programmed WR cycles.
// R08: Device starts internal write 4 CK after WL, 2 for fixed BC4.
// R09: CKE may drop while activate, precharge or refresh is in progress.
// R10: Power-down entered during refresh adds DLL-locked exit time on exit.
// R11: MRS after an MPR read burst waits for the burst and gap.
// R12: Short ZQ calibration finishes within 64 CK; commands wait meanwhile.
// R13: CK period may grow freely if refresh interval still holds.
// R14: After REF, at least one CK before CKE goes low.
// R15: Separate counters per spacing; violating commands are held back.
`timescale 1ns/10ps
module drt_seq (
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    cmd_valid,
	input  wire logic [3:0]              cmd_op,
	input  wire logic [drt_pkg::AW-1:0]  cmd_addr,
	input  wire logic [drt_pkg::BW-1:0]  cmd_ba,
	input  wire logic [drt_pkg::CW-1:0]  cfg_wl,
	input  wire logic [drt_pkg::CW-1:0]  cfg_rl,
	input  wire logic [drt_pkg::CW-1:0]  cfg_wr,
	input  wire logic                    cfg_bc4_mrs,
	input  wire logic                    temp_hot,
	input  wire logic                    dq0_fb_i,
	input  wire logic                    dqs_i,
	output wire logic                    cmd_ack,
	output wire logic                    ref_done,
	output wire logic                    wl_fb,
	output wire logic                    ck,
	output wire logic                    ck_n,
	output wire logic                    cke,
	output wire logic                    cs_n,
	output wire logic                    ras_n,
	output wire logic                    cas_n,
	output wire logic                    we_n,
	output wire logic [drt_pkg::AW-1:0]  addr,
	output wire logic [drt_pkg::BW-1:0]  ba,
	output wire logic                    dqs_o,
	output wire logic                    dqs_oe_n
);
	drt_tmr_if tif ();

	logic [1:0]               ph_q;
	logic                     ck_q;
	logic                     ck_n_q;
	logic                     launch;
	drt_pkg::drt_op_t         op;
	drt_pkg::drt_st_t         st_q;
	logic                     run_free;
	logic                     ok;
	logic                     ref_go;
	logic                     user_go;
	logic                     ref_any;
	logic                     ref_pend_q;
	logic [drt_pkg::TW-1:0]   refi_q;
	logic [drt_pkg::TW-1:0]   refi_top;
	logic [drt_pkg::TW-1:0]   wr_need;
	logic [drt_pkg::TW-1:0]   mpr_need;
	logic                     ref_in_pd_q;
	logic [2:0]               rcw_d;
	logic                     a10_d;
	logic [2:0]               rcw_q;
	logic                     cs_n_q;
	logic [drt_pkg::AW-1:0]   addr_q;
	logic [drt_pkg::BW-1:0]   ba_q;
	logic                     cke_q;
	logic                     dqs_q;
	logic                     dqs_oe_n_q;
	logic                     fb_s1_q;
	logic                     fb_s2_q;
	logic                     ack_q;
	logic                     ref_done_q;

	// Spacing timers, one per minimum
	genvar gi;
	generate
		for (gi = 0; gi < drt_pkg::NT; gi++) begin : g_tmr
			drt_timer #(.IDX(gi)) u_tmr (
				.clk_sys (clk_sys),
				.rst     (rst),
				.t       (tif)
			);
		end
	endgenerate

	// CK made by division; no second domain since this end owns the clock
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ph_q   <= 2'h0;
			ck_q   <= 1'b0;
			ck_n_q <= 1'b1;
		end else begin
			ph_q <= ph_q + 2'h1;
			if (ph_q == drt_pkg::CK_LAST) begin
				ck_q   <= 1'b1;
				ck_n_q <= 1'b0;
			end else if (ph_q == drt_pkg::CK_FALL) begin
				ck_q   <= 1'b0;
				ck_n_q <= 1'b1;
			end
		end
	end

	// Timers advance once per CK, at the edge where CK rises
	assign tif.tick = (ph_q == drt_pkg::CK_LAST);
	// Pins change mid-low so they are stable at the rising edge
	assign launch   = (ph_q == drt_pkg::CK_LAUNCH);
	assign op       = drt_pkg::drt_op_t'(cmd_op);

	// R08: write start offset
	assign wr_need = {5'h00, cfg_wl} + (cfg_bc4_mrs ? drt_pkg::WR_START_BC4 : drt_pkg::WR_START_BL8)
		+ ((op == drt_pkg::OP_WRA) ? ({5'h00, cfg_wr} + drt_pkg::ONE_NCK) : drt_pkg::WR_CEIL_NCK);
	assign mpr_need = {5'h00, cfg_rl} + drt_pkg::BURST_NCK + drt_pkg::MPRR_NCK;

	// R15: legality per command
	assign run_free = (st_q == drt_pkg::ST_RUN) && !tif.busy[drt_pkg::T_ZQ]
		&& !tif.busy[drt_pkg::T_XP];
	always_comb begin
		ok = 1'b0;
		case (op)
			drt_pkg::OP_NOP: ok = 1'b1;
			// R03: refresh recovery
			drt_pkg::OP_ACT, drt_pkg::OP_REF: ok = run_free && !tif.busy[drt_pkg::T_RFC];
			// R05: DLL-locked exit
			drt_pkg::OP_RD, drt_pkg::OP_RDA, drt_pkg::OP_MPR_RD: ok = run_free
				&& !tif.busy[drt_pkg::T_XPDLL];
			drt_pkg::OP_PRE, drt_pkg::OP_WR, drt_pkg::OP_WRA, drt_pkg::OP_ZQCS: ok = run_free;
			// R11: MPR to MRS
			drt_pkg::OP_MRS, drt_pkg::OP_WL_ON: ok = run_free && !tif.busy[drt_pkg::T_MPR];
			// R09: refresh may still run
			drt_pkg::OP_PDE: ok = run_free && !tif.busy[drt_pkg::T_REFPD]
				&& !tif.busy[drt_pkg::T_WRPD];
			drt_pkg::OP_PDX: ok = (st_q == drt_pkg::ST_PDOWN) && !tif.busy[drt_pkg::T_CKE];
			// R01: leveling strobe delay
			drt_pkg::OP_WL_PULSE: ok = (st_q == drt_pkg::ST_WLVL) && !tif.busy[drt_pkg::T_WLMRD]
				&& !tif.busy[drt_pkg::T_WLDQSEN] && !dqs_q;
			drt_pkg::OP_WL_OFF: ok = (st_q == drt_pkg::ST_WLVL) && !dqs_q;
			default: ok = 1'b0;
		endcase
	end

	// R04: in run mode a pending refresh goes first and holds user commands back
	assign ref_go  = launch && ref_pend_q && run_free && !tif.busy[drt_pkg::T_RFC];
	assign user_go = launch && cmd_valid && ok && !(ref_pend_q && (st_q == drt_pkg::ST_RUN));
	assign ref_any = ref_go || (user_go && (op == drt_pkg::OP_REF));

	// R13: interval counted in CK periods derived from the actual CK period
	assign refi_top = temp_hot ? drt_pkg::REFI_HOT_NCK : drt_pkg::REFI_NORM_NCK;

	// R04: interval counter; only one refresh is owed at a time
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			refi_q     <= drt_pkg::REFI_NORM_NCK;
			ref_pend_q <= 1'b0;
		end else begin
			if (tif.tick) begin
				if (refi_q <= drt_pkg::ONE_NCK) begin
					refi_q <= refi_top;
				end else if (refi_q > refi_top) begin
					refi_q <= refi_top;
				end else begin
					refi_q <= refi_q - drt_pkg::ONE_NCK;
				end
			end
			// Set wins over clear
			if (tif.tick && (refi_q == drt_pkg::ONE_NCK)) begin
				ref_pend_q <= 1'b1;
			end else if (ref_go) begin
				ref_pend_q <= 1'b0;
			end
		end
	end

	// R15: timer loads on issued commands that open a spacing window
	always_comb begin
		for (int i = 0; i < drt_pkg::NT; i++) begin
			tif.load[i] = 1'b0;
			tif.val[i]  = '0;
		end
		// R03: refresh recovery window
		if (ref_any) begin
			tif.load[drt_pkg::T_RFC]   = 1'b1;
			tif.val[drt_pkg::T_RFC]    = drt_pkg::RFC_NCK;
			// R14: one CK to power-down
			tif.load[drt_pkg::T_REFPD] = 1'b1;
			tif.val[drt_pkg::T_REFPD]  = drt_pkg::REFPDEN_NCK;
		end
		if (user_go) begin
			case (op)
				// R06: rounded-up write recovery
				drt_pkg::OP_WR, drt_pkg::OP_WRA: begin
					// R07: programmed WR cycles
					tif.load[drt_pkg::T_WRPD] = 1'b1;
					tif.val[drt_pkg::T_WRPD]  = wr_need;
				end
				// R12: calibration busy window
				drt_pkg::OP_ZQCS: begin
					tif.load[drt_pkg::T_ZQ] = 1'b1;
					tif.val[drt_pkg::T_ZQ]  = drt_pkg::ZQCS_NCK;
				end
				// R11: burst plus gap
				drt_pkg::OP_MPR_RD: begin
					tif.load[drt_pkg::T_MPR] = 1'b1;
					tif.val[drt_pkg::T_MPR]  = mpr_need;
				end
				// R02: leveling strobe windows
				drt_pkg::OP_WL_ON: begin
					// One extra CK: the MRS edge itself is the first tick, and the
					// strobe pins move a system cycle ahead of the CK rise
					tif.load[drt_pkg::T_WLMRD]   = 1'b1;
					tif.val[drt_pkg::T_WLMRD]    = drt_pkg::WLMRD_NCK + drt_pkg::ONE_NCK;
					tif.load[drt_pkg::T_WLDQSEN] = 1'b1;
					tif.val[drt_pkg::T_WLDQSEN]  = drt_pkg::WLDQSEN_NCK + drt_pkg::ONE_NCK;
				end
				drt_pkg::OP_PDE: begin
					tif.load[drt_pkg::T_CKE] = 1'b1;
					tif.val[drt_pkg::T_CKE]  = drt_pkg::CKE_NCK;
				end
				// R10: exit after refresh-time entry waits the longer time
				drt_pkg::OP_PDX: begin
					tif.load[drt_pkg::T_XP]    = 1'b1;
					tif.val[drt_pkg::T_XP]     = ref_in_pd_q ? drt_pkg::XPDLL_NCK : drt_pkg::XP_NCK;
					tif.load[drt_pkg::T_XPDLL] = 1'b1;
					tif.val[drt_pkg::T_XPDLL]  = drt_pkg::XPDLL_NCK;
				end
				default: ;
			endcase
		end
	end

	// Command encoding; deselect when nothing issues
	always_comb begin
		rcw_d = drt_pkg::CMD_NOP;
		a10_d = cmd_addr[10];
		if (ref_go) begin
			rcw_d = drt_pkg::CMD_REF;
		end else if (user_go) begin
			case (op)
				drt_pkg::OP_ACT: rcw_d = drt_pkg::CMD_ACT;
				drt_pkg::OP_PRE: rcw_d = drt_pkg::CMD_PRE;
				drt_pkg::OP_REF: rcw_d = drt_pkg::CMD_REF;
				drt_pkg::OP_RD, drt_pkg::OP_MPR_RD: begin
					rcw_d = drt_pkg::CMD_RD;
					a10_d = 1'b0;
				end
				drt_pkg::OP_RDA: begin
					rcw_d = drt_pkg::CMD_RD;
					a10_d = 1'b1;
				end
				drt_pkg::OP_WR: begin
					rcw_d = drt_pkg::CMD_WR;
					a10_d = 1'b0;
				end
				drt_pkg::OP_WRA: begin
					rcw_d = drt_pkg::CMD_WR;
					a10_d = 1'b1;
				end
				drt_pkg::OP_MRS, drt_pkg::OP_WL_ON, drt_pkg::OP_WL_OFF: rcw_d = drt_pkg::CMD_MRS;
				drt_pkg::OP_ZQCS: begin
					rcw_d = drt_pkg::CMD_ZQ;
					a10_d = 1'b0;
				end
				default: rcw_d = drt_pkg::CMD_NOP;
			endcase
		end
	end

	// Command pins, held for one CK each
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rcw_q  <= drt_pkg::CMD_NOP;
			cs_n_q <= 1'b1;
			addr_q <= '0;
			ba_q   <= '0;
		end else if (launch) begin
			rcw_q  <= rcw_d;
			cs_n_q <= (rcw_d == drt_pkg::CMD_NOP);
			addr_q <= {cmd_addr[13:11], a10_d, cmd_addr[9:0]};
			ba_q   <= cmd_ba;
		end
	end

	// Mode state, CKE and refresh-in-entry flag
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q        <= drt_pkg::ST_RUN;
			cke_q       <= 1'b1;
			ref_in_pd_q <= 1'b0;
		end else if (user_go) begin
			case (op)
				drt_pkg::OP_WL_ON: st_q <= drt_pkg::ST_WLVL;
				drt_pkg::OP_WL_OFF: st_q <= drt_pkg::ST_RUN;
				// R09: entry allowed while refresh runs
				drt_pkg::OP_PDE: begin
					st_q        <= drt_pkg::ST_PDOWN;
					cke_q       <= 1'b0;
					ref_in_pd_q <= tif.busy[drt_pkg::T_RFC];
				end
				drt_pkg::OP_PDX: begin
					st_q  <= drt_pkg::ST_RUN;
					cke_q <= 1'b1;
				end
				default: ;
			endcase
		end
	end

	// Leveling strobe: one CK high per pulse; driver off outside leveling
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dqs_q      <= 1'b0;
			dqs_oe_n_q <= 1'b1;
		end else begin
			if (launch) begin
				dqs_q <= user_go && (op == drt_pkg::OP_WL_PULSE);
			end
			// R02: strobe driver enable delay; off together with leaving leveling
			dqs_oe_n_q <= !((st_q == drt_pkg::ST_WLVL) && !tif.busy[drt_pkg::T_WLDQSEN]
				&& !(user_go && (op == drt_pkg::OP_WL_OFF)));
		end
	end

	// Leveling feedback from a pin, two flops before use
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fb_s1_q    <= 1'b0;
			fb_s2_q    <= 1'b0;
			ack_q      <= 1'b0;
			ref_done_q <= 1'b0;
		end else begin
			fb_s1_q    <= dq0_fb_i;
			fb_s2_q    <= fb_s1_q;
			ack_q      <= user_go;
			ref_done_q <= ref_go;
		end
	end

	assign cmd_ack  = ack_q;
	assign ref_done = ref_done_q;
	assign wl_fb    = fb_s2_q;
	assign ck       = ck_q;
	assign ck_n     = ck_n_q;
	assign cke      = cke_q;
	assign cs_n     = cs_n_q;
	assign ras_n    = rcw_q[2];
	assign cas_n    = rcw_q[1];
	assign we_n     = rcw_q[0];
	assign addr     = addr_q;
	assign ba       = ba_q;
	assign dqs_o    = dqs_q;
	assign dqs_oe_n = dqs_oe_n_q;

	// Checking aid: CK periods since each event, saturating
	logic                   ev [drt_pkg::NE];
	logic [drt_pkg::TW-1:0] since_q [drt_pkg::NE];
	logic [drt_pkg::TW-1:0] wr_need_q;
	logic [drt_pkg::TW-1:0] mpr_need_q;
	assign ev[drt_pkg::E_REF] = ref_any;
	assign ev[drt_pkg::E_WL]  = user_go && (op == drt_pkg::OP_WL_ON);
	assign ev[drt_pkg::E_ZQ]  = user_go && (op == drt_pkg::OP_ZQCS);
	assign ev[drt_pkg::E_WR]  = user_go && ((op == drt_pkg::OP_WR) || (op == drt_pkg::OP_WRA));
	assign ev[drt_pkg::E_PDX] = user_go && (op == drt_pkg::OP_PDX);
	assign ev[drt_pkg::E_MPR] = user_go && (op == drt_pkg::OP_MPR_RD);
	for (gi = 0; gi < drt_pkg::NE; gi++) begin : g_since
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				since_q[gi] <= drt_pkg::SAT_NCK;
			end else if (ev[gi]) begin
				since_q[gi] <= '0;
			end else if (tif.tick && (since_q[gi] != drt_pkg::SAT_NCK)) begin
				since_q[gi] <= since_q[gi] + drt_pkg::ONE_NCK;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_need_q  <= '0;
			mpr_need_q <= '0;
		end else begin
			if (ev[drt_pkg::E_WR]) wr_need_q <= wr_need;
			if (ev[drt_pkg::E_MPR]) mpr_need_q <= mpr_need;
		end
	end

	// R01: first strobe edge spacing; count includes the MRS edge, so strictly more
	property p_wlmrd;
		@(posedge clk_sys) disable iff (rst)
		(user_go && (op == drt_pkg::OP_WL_PULSE)) |-> (since_q[drt_pkg::E_WL] > drt_pkg::WLMRD_NCK);
	endproperty
	a_wlmrd: assert property (p_wlmrd) else $error("strobe edge too early"); // R01
	// R01: pulse shape
	property p_pulse;
		@(posedge clk_sys) disable iff (rst)
		(user_go && (op == drt_pkg::OP_WL_PULSE)) |=> dqs_o [*4] ##1 !dqs_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("strobe pulse not one CK"); // R01
	// R02: driver stays off
	property p_wldqsen;
		@(posedge clk_sys) disable iff (rst)
		!dqs_oe_n |-> (since_q[drt_pkg::E_WL] > drt_pkg::WLDQSEN_NCK) && (st_q == drt_pkg::ST_WLVL);
	endproperty
	a_wldqsen: assert property (p_wldqsen) else $error("strobe driven too early"); // R02
	// R03: refresh recovery
	property p_rfc;
		@(posedge clk_sys) disable iff (rst)
		(ref_any || (user_go && (op == drt_pkg::OP_ACT))) |->
			(since_q[drt_pkg::E_REF] >= drt_pkg::RFC_NCK);
	endproperty
	a_rfc: assert property (p_rfc) else $error("ACT or REF inside refresh time"); // R03
	// R04: refresh owed at interval end
	property p_refi;
		@(posedge clk_sys) disable iff (rst)
		(tif.tick && (refi_q == drt_pkg::ONE_NCK)) |=> ref_pend_q;
	endproperty
	a_refi: assert property (p_refi) else $error("refresh not requested"); // R04
	// R04: owed refresh goes out once calibration or exit time lets it
	property p_refnow;
		@(posedge clk_sys) disable iff (rst)
		(ref_pend_q && (st_q == drt_pkg::ST_RUN)) |-> ##[0:300] ref_done;
	endproperty
	a_refnow: assert property (p_refnow) else $error("owed refresh not issued"); // R04
	// R05: DLL commands after exit
	property p_dll;
		@(posedge clk_sys) disable iff (rst)
		(user_go && ((op == drt_pkg::OP_RD) || (op == drt_pkg::OP_RDA))) |->
			(since_q[drt_pkg::E_PDX] >= drt_pkg::XPDLL_NCK);
	endproperty
	a_dll: assert property (p_dll) else $error("read before DLL exit time"); // R05
	// R06: write to power-down
	property p_wrpd;
		@(posedge clk_sys) disable iff (rst)
		(user_go && (op == drt_pkg::OP_PDE)) |-> (since_q[drt_pkg::E_WR] >= wr_need_q);
	endproperty
	a_wrpd: assert property (p_wrpd) else $error("power-down too soon after write"); // R06
	// R11: MPR to MRS
	property p_mpr;
		@(posedge clk_sys) disable iff (rst)
		(launch && (rcw_d == drt_pkg::CMD_MRS)) |-> (since_q[drt_pkg::E_MPR] >= mpr_need_q);
	endproperty
	a_mpr: assert property (p_mpr) else $error("MRS too soon after MPR read"); // R11
	// R12: calibration quiet time
	property p_zq;
		@(posedge clk_sys) disable iff (rst)
		(ref_go || (user_go && (op != drt_pkg::OP_NOP))) |-> (since_q[drt_pkg::E_ZQ] >= drt_pkg::ZQCS_NCK);
	endproperty
	a_zq: assert property (p_zq) else $error("command during calibration"); // R12
	// R14: refresh to power-down
	property p_refpd;
		@(posedge clk_sys) disable iff (rst)
		(user_go && (op == drt_pkg::OP_PDE)) |-> (since_q[drt_pkg::E_REF] >= drt_pkg::REFPDEN_NCK);
	endproperty
	a_refpd: assert property (p_refpd) else $error("CKE low right at refresh"); // R14
	// R15: CKE low width
	property p_cke;
		@(posedge clk_sys) disable iff (rst)
		(user_go && (op == drt_pkg::OP_PDE)) |=> !cke [*8];
	endproperty
	a_cke: assert property (p_cke) else $error("CKE low pulse too short"); // R15
endmodule

// ---- rtl/drt_timer.sv ----
// One spacing timer counting CK periods down to zero
`timescale 1ns/10ps
module drt_timer #(
	parameter int IDX = 0
) (
	input wire logic clk_sys,
	input wire logic rst,
	drt_tmr_if.tmr   t
);
	logic [drt_pkg::TW-1:0] cnt_q;

	// Load wins over the count so a new command restarts its window
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (t.load[IDX]) begin
			cnt_q <= t.val[IDX];
		end else if (t.tick && (cnt_q != '0)) begin
			cnt_q <= cnt_q - drt_pkg::ONE_NCK;
		end
	end

	// Busy while any part of the minimum is still open
	assign t.busy[IDX] = (cnt_q != '0);
endmodule

// ---- rtl/drt_tmr_if.sv ----
// Interface between the sequencer and its spacing timers
`timescale 1ns/10ps
interface drt_tmr_if;
	logic                    tick;
	logic                    load [drt_pkg::NT];
	logic [drt_pkg::TW-1:0]  val  [drt_pkg::NT];
	logic                    busy [drt_pkg::NT];
	modport ctl (output tick, output load, output val, input busy);
	modport tmr (input tick, input load, input val, output busy);
endinterface

// ---- sim/drt_ddr3_model.sv ----
// Behavioural DDR3 device: spacing checks and leveling feedback
`timescale 1ns/10ps
module drt_ddr3_model (
	input  wire logic                   ck,
	input  wire logic                   cke,
	input  wire logic                   cs_n,
	input  wire logic                   ras_n,
	input  wire logic                   cas_n,
	input  wire logic                   we_n,
	input  wire logic [drt_pkg::AW-1:0] addr,
	input  wire logic [drt_pkg::BW-1:0] ba,
	input  wire logic                   dqs_o,
	input  wire logic                   dqs_oe_n,
	output logic                        dq0_fb,
	output logic [7:0]                  n_viol
);
	logic [2:0] cmd;
	logic       cke_q = 1'b1;
	logic       wl_on = 1'b0;
	int         c_ref = 1000;
	int         c_wl  = 1000;
	int         c_zq  = 1000;
	int         c_wr  = 1000;
	assign cmd = {ras_n, cas_n, we_n};
	initial n_viol = 8'h00;
	initial dq0_fb = 1'b0;
	// Decode on CK rise; elapsed counts saturate so idle time never wraps
	always @(posedge ck) begin
		c_ref = (c_ref < 1000) ? c_ref + 1 : c_ref;
		c_wl  = (c_wl < 1000) ? c_wl + 1 : c_wl;
		c_zq  = (c_zq < 1000) ? c_zq + 1 : c_zq;
		c_wr  = (c_wr < 1000) ? c_wr + 1 : c_wr;
		if (!cs_n && cke && (cmd == drt_pkg::CMD_ACT || cmd == drt_pkg::CMD_REF) && c_ref < 7)
			n_viol = n_viol + 8'h01;
		if (!cs_n && cke && cmd != drt_pkg::CMD_NOP && c_zq < 64)
			n_viol = n_viol + 8'h01;
		// CKE low after REF; refresh may still run
		if (!cke && cke_q && c_ref < 1)
			n_viol = n_viol + 8'h01;
		// internal write starts WL+4 (WL is 5), then one CK recovery
		if (!cke && cke_q && c_wr < 10)
			n_viol = n_viol + 8'h01;
		cke_q = cke;
		if (!cs_n && cke && cmd == drt_pkg::CMD_WR)
			c_wr = 0;
		if (!cs_n && cke && cmd == drt_pkg::CMD_REF)
			c_ref = 0;
		if (!cs_n && cke && cmd == drt_pkg::CMD_ZQ)
			c_zq = 0;
		if (!cs_n && cke && cmd == drt_pkg::CMD_MRS && ba == 3'h1) begin
			wl_on = addr[7];
			c_wl  = 0;
		end
		// Outside leveling the pin is not driven: give a changing level
		if (!wl_on)
			dq0_fb = ~dq0_fb;
	end
	always @(posedge dqs_o) begin
		if (c_wl < 40)
			n_viol = n_viol + 8'h01;
		dq0_fb = wl_on ? ck : ~dq0_fb;
	end
	always @(negedge dqs_oe_n) begin
		if (c_wl < 25)
			n_viol = n_viol + 8'h01;
	end
endmodule

// ---- sim/drt_seq_tb.sv ----
// Self-checking bench for the DDR3 timing sequencer
`timescale 1ns/10ps
module drt_seq_tb;
	logic                   clk_sys = 1'b0;
	logic                   rst = 1'b1;
	logic                   cmd_valid = 1'b0;
	logic [3:0]             cmd_op = 4'h0;
	logic [drt_pkg::AW-1:0] cmd_addr = 14'h0000;
	logic [drt_pkg::BW-1:0] cmd_ba = 3'h0;
	logic                   temp_hot = 1'b0;
	logic                   dq0_fb, cmd_ack, ref_done, wl_fb, ck, ck_n, cke;
	logic                   cs_n, ras_n, cas_n, we_n, dqs_o, dqs_oe_n;
	logic [drt_pkg::AW-1:0] addr;
	logic [drt_pkg::BW-1:0] ba;
	logic [7:0]             n_viol;
	int                     n_fail = 0;
	int                     n_checks = 0;
	int                     lat;
	logic [4:0]             pins;

	drt_seq u_drt_seq (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_ba(cmd_ba), .cfg_wl(5'h05), .cfg_rl(5'h06), .cfg_wr(5'h06),
		.cfg_bc4_mrs(1'b0), .temp_hot(temp_hot), .dq0_fb_i(dq0_fb), .dqs_i(1'b0),
		.cmd_ack(cmd_ack), .ref_done(ref_done), .wl_fb(wl_fb), .ck(ck), .ck_n(ck_n), .cke(cke),
		.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .ba(ba),
		.dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n));
	drt_ddr3_model u_drt_ddr3_model (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .addr(addr), .ba(ba), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n),
		.dq0_fb(dq0_fb), .n_viol(n_viol));

	// 250 MHz system clock
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input bit ok, input string msg);
		n_checks++;
		if (!ok) begin
			n_fail++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask

	// One request held until acknowledged; latency in system cycles
	task automatic cmd(input drt_pkg::drt_op_t op, input logic [13:0] a, input logic [2:0] b);
		lat = 0;
		@(posedge clk_sys);
		cmd_op <= op;
		cmd_addr <= a;
		cmd_ba <= b;
		cmd_valid <= 1'b1;
		for (lat = 1; lat < 3000; lat++) begin
			@(posedge clk_sys);
			#1;
			if (cmd_ack === 1'b1)
				break;
		end
		pins = {cke, cs_n, ras_n, cas_n, we_n};
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		if (lat >= 3000) begin
			chk(0, "request never acknowledged");
			stop_test();
		end
	endtask

	// Bounded wait for the next internal refresh
	task automatic wait_ref();
		for (lat = 1; lat < 3000; lat++) begin
			@(posedge clk_sys);
			#1;
			if (ref_done === 1'b1)
				break;
		end
		if (lat >= 3000) begin
			chk(0, "no refresh issued");
			stop_test();
		end
	endtask

	task automatic t_rfc();
		wait_ref();
		cmd(drt_pkg::OP_REF, 14'h0000, 3'h0);
		chk(lat >= 24, "REF too soon after refresh");
		cmd(drt_pkg::OP_ACT, 14'h0123, 3'h5);
		chk(lat >= 24, "ACT too soon after REF");
		chk(pins === 5'h13 && addr === 14'h0123 && ba === 3'h5, "ACT pins wrong");
	endtask

	task automatic t_pdown();
		wait_ref();
		cmd(drt_pkg::OP_PDE, 14'h0000, 3'h0);
		chk(pins[4] === 1'b0, "CKE not low");
		cmd(drt_pkg::OP_PDX, 14'h0000, 3'h0);
		chk(pins[4] === 1'b1, "CKE not high");
		cmd(drt_pkg::OP_PRE, 14'h0000, 3'h0);
		chk(lat >= 36, "exit wait too short");
	endtask

	task automatic t_wrpd();
		cmd(drt_pkg::OP_WR, 14'h0400, 3'h0);
		chk(pins === 5'h14 && addr[10] === 1'b0, "WR pins wrong");
		cmd(drt_pkg::OP_PDE, 14'h0000, 3'h0);
		chk(lat >= 38, "power-down too soon after WR");
		cmd(drt_pkg::OP_PDX, 14'h0000, 3'h0);
		cmd(drt_pkg::OP_WRA, 14'h0000, 3'h0);
		cmd(drt_pkg::OP_PDE, 14'h0000, 3'h0);
		chk(lat >= 62, "power-down too soon after WRA");
		cmd(drt_pkg::OP_PDX, 14'h0000, 3'h0);
		cmd(drt_pkg::OP_RD, 14'h0000, 3'h0);
		chk(lat >= 38, "read before DLL exit time");
		cmd(drt_pkg::OP_MPR_RD, 14'h0000, 3'h0);
		cmd(drt_pkg::OP_MRS, 14'h0000, 3'h3);
		chk(lat >= 42, "MRS too soon after MPR read");
	endtask

	task automatic t_zq();
		cmd(drt_pkg::OP_ZQCS, 14'h0000, 3'h0);
		cmd(drt_pkg::OP_PRE, 14'h0000, 3'h0);
		chk(lat >= 252, "command during calibration");
	endtask

	task automatic t_wlvl();
		cmd(drt_pkg::OP_WL_ON, 14'h0080, 3'h1);
		chk(dqs_oe_n === 1'b1, "strobe driven early");
		cmd(drt_pkg::OP_WL_PULSE, 14'h0000, 3'h0);
		chk(lat >= 150, "strobe pulse too early");
		chk(dqs_oe_n === 1'b0, "strobe not driven");
		repeat (8) @(posedge clk_sys);
		#1;
		chk(wl_fb === dq0_fb, "feedback not followed");
		cmd(drt_pkg::OP_WL_OFF, 14'h0000, 3'h1);
		chk(dqs_oe_n === 1'b1, "strobe still driven");
	endtask

	task automatic t_refi();
		wait_ref();
		wait_ref();
		chk(lat >= 1940 && lat <= 1950, "normal refresh gap");
		@(posedge clk_sys);
		temp_hot <= 1'b1;
		wait_ref();
		wait_ref();
		chk(lat >= 960 && lat <= 975, "hot refresh gap");
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk(cke === 1'b1 && cs_n === 1'b1 && dqs_oe_n === 1'b1 && cmd_ack === 1'b0, "reset pins");
		t_rfc();
		t_pdown();
		t_wrpd();
		t_zq();
		t_wlvl();
		t_refi();
		chk(n_viol === 8'h00, "device saw spacing violation");
		stop_test();
	end
endmodule
